// file: rtl/ocs_clock_switch.sv
// oscillator source selection, gated handover that holds the output low until the new source is low, and times-four/times-two clocks
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ocs_defines.svh"
`default_nettype none

module ocs_clock_switch #(
    parameter logic [7:0] TRIM_RESET = `OCS_TRIM_RST
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    output var  logic [7:0] reg_rdata_o,
    // system integration unit
    input  wire logic       integration_osc_enable_i,
    input  wire logic       osc_run_in_stop_cfg_i,
    // raw source clocks
    input  wire logic       internal_osc_clock_i,
    input  wire logic       crystal_clock_i,
    input  wire logic       resistor_cap_clock_i,
    input  wire logic       osc_pin_one_i,
    // oscillator controls
    output var  logic       internal_osc_enable_o,
    output var  logic       crystal_osc_enable_o,
    output var  logic       rc_osc_enable_o,
    output var  logic [1:0] internal_freq_field_o,
    output var  logic [7:0] internal_trim_value_o,
    output var  logic [1:0] crystal_range_field_o,
    // pins
    output var  logic       pin1_clock_input_en_o,
    output var  logic       pin2_crystal_mode_o,
    output var  logic       osc_pin_two_o,
    output var  logic       osc_pin_two_oe_o,
    // clocks and status
    output var  logic       bus_clock_times_four_o,
    output var  logic       bus_clock_times_two_o,
    output var  logic       external_clock_engaged_o
);

    // ============================================================
    // source synchronisers
    // index 0 internal, 1 crystal, 2 rc, 3 pin one
    localparam int SRC_INT  = 0;
    localparam int SRC_XTAL = 1;
    localparam int SRC_RC   = 2;
    localparam int SRC_PIN1 = 3;

    logic [3:0] src_raw;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;

    assign src_raw = {osc_pin_one_i, resistor_cap_clock_i, crystal_clock_i, internal_osc_clock_i};

    // sampled clocks: sources must stay well below half of clk_i to be seen
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end
        else
        begin
            sync1_reg <= src_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // ============================================================
    // register file
    ocs_pkg::ocs_ctrl_s ctrl_reg;
    ocs_pkg::ocs_ctrl_s ctrl_next;
    logic [7:0]         trim_reg;
    logic [7:0]         trim_next;
    logic               pin2_en_reg;
    logic               pin2_en_next;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;
    logic               engaged_reg;

    always_comb
    begin
        ctrl_next    = ctrl_reg;
        trim_next    = trim_reg;
        pin2_en_next = pin2_en_reg;
        rdata_next   = 8'h00;
        if (reg_write_i && reg_addr_i == `OCS_ADDR_CTRL)
        begin
            ctrl_next.source_option_field =
                ocs_pkg::ocs_opt_e'(reg_wdata_i[`OCS_OPT_LSB +: 2]);
            ctrl_next.crystal_range_field = reg_wdata_i[`OCS_RANGE_LSB +: 2];
            ctrl_next.external_clock_on   = reg_wdata_i[`OCS_EXT_ON_BIT];
            // the reserved encoding is refused so the oscillator never sees it
            if (reg_wdata_i[`OCS_FREQ_LSB +: 2] != ocs_pkg::FREQ_RESERVED)
            begin
                ctrl_next.internal_freq_field =
                    ocs_pkg::ocs_freq_e'(reg_wdata_i[`OCS_FREQ_LSB +: 2]);
            end
        end
        // only software writes change the trim; reset loads the fixed TRIM_RESET
        if (reg_write_i && reg_addr_i == `OCS_ADDR_TRIM)
        begin
            trim_next = reg_wdata_i;
        end
        if (reg_write_i && reg_addr_i == `OCS_ADDR_PIN2)
        begin
            pin2_en_next = reg_wdata_i[`OCS_PIN2_EN_BIT];
        end
        if (ctrl_next.source_option_field == ocs_pkg::OPT_EXT_CLOCK)
        begin
            pin2_en_next = 1'b0;
        end
        if (reg_read_i)
        begin
            case (reg_addr_i)
                `OCS_ADDR_CTRL: rdata_next = {ctrl_reg, engaged_reg};
                `OCS_ADDR_TRIM: rdata_next = trim_reg;
                `OCS_ADDR_PIN2: rdata_next = {7'h00, pin2_en_reg};
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_reg    <= '{ocs_pkg::ocs_opt_e'(`OCS_OPT_RST),
                             ocs_pkg::ocs_freq_e'(`OCS_FREQ_RST),
                             `OCS_RANGE_RST, 1'b0};
            trim_reg    <= TRIM_RESET;
            pin2_en_reg <= 1'b0;
            rdata_reg   <= 8'h00;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            trim_reg    <= trim_next;
            pin2_en_reg <= pin2_en_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ============================================================
    // handover state machine
    ocs_pkg::ocs_state_e state_reg;
    ocs_pkg::ocs_state_e state_next;
    logic [1:0]          edge_cnt_reg;
    logic [1:0]          edge_cnt_next;
    logic                engaged_next;
    logic                ext_lvl;
    logic                ext_rise;
    logic                int_lvl;
    logic                int_rise;
    logic                abort;
    logic                sel_lvl;

    always_comb
    begin
        case (ctrl_reg.source_option_field)
            ocs_pkg::OPT_EXT_CLOCK: ext_lvl = sync2_reg[SRC_PIN1];
            ocs_pkg::OPT_RC:        ext_lvl = sync2_reg[SRC_RC];
            ocs_pkg::OPT_CRYSTAL:   ext_lvl = sync2_reg[SRC_XTAL];
            default:                ext_lvl = 1'b0;
        endcase
        case (ctrl_reg.source_option_field)
            ocs_pkg::OPT_EXT_CLOCK: ext_rise = sync2_reg[SRC_PIN1] & ~sync3_reg[SRC_PIN1];
            ocs_pkg::OPT_RC:        ext_rise = sync2_reg[SRC_RC] & ~sync3_reg[SRC_RC];
            ocs_pkg::OPT_CRYSTAL:   ext_rise = sync2_reg[SRC_XTAL] & ~sync3_reg[SRC_XTAL];
            default:                ext_rise = 1'b0;
        endcase
        int_lvl  = sync2_reg[SRC_INT];
        int_rise = sync2_reg[SRC_INT] & ~sync3_reg[SRC_INT];
        abort    = ctrl_reg.source_option_field == ocs_pkg::OPT_INTERNAL
                   || !ctrl_reg.external_clock_on;
        state_next    = state_reg;
        edge_cnt_next = edge_cnt_reg;
        engaged_next  = engaged_reg;
        sel_lvl       = 1'b0;
        case (state_reg)
            ocs_pkg::ST_INT:
            begin
                sel_lvl       = int_lvl;
                edge_cnt_next = 2'h0;
                if (!abort)
                begin
                    state_next = ocs_pkg::ST_CHECK;
                end
            end
            ocs_pkg::ST_CHECK:
            begin
                sel_lvl = int_lvl;
                if (abort)
                begin
                    state_next = ocs_pkg::ST_INT;
                end
                else if (edge_cnt_reg == `OCS_EDGES_NEEDED)
                begin
                    state_next = ocs_pkg::ST_GATE_EXT;
                end
                else if (ext_rise)
                begin
                    edge_cnt_next = edge_cnt_reg + 2'h1;
                end
            end
            ocs_pkg::ST_GATE_EXT:
            begin
                // output held low until the new source is low too
                sel_lvl = 1'b0;
                if (!ext_lvl)
                begin
                    state_next   = ocs_pkg::ST_EXT;
                    engaged_next = 1'b1;
                end
            end
            ocs_pkg::ST_EXT:
            begin
                sel_lvl = ext_lvl;
                if (ctrl_reg.source_option_field == ocs_pkg::OPT_INTERNAL
                    && !ctrl_reg.external_clock_on && !ext_lvl)
                begin
                    state_next    = ocs_pkg::ST_RETURN;
                    edge_cnt_next = 2'h0;
                end
            end
            ocs_pkg::ST_RETURN:
            begin
                // internal restarts; prove it runs before leaning on it
                sel_lvl = 1'b0;
                if (edge_cnt_reg != `OCS_EDGES_NEEDED)
                begin
                    if (int_rise)
                    begin
                        edge_cnt_next = edge_cnt_reg + 2'h1;
                    end
                end
                else if (!int_lvl)
                begin
                    state_next   = ocs_pkg::ST_INT;
                    engaged_next = 1'b0;
                end
            end
            default:
            begin
                state_next = ocs_pkg::ST_INT;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg    <= ocs_pkg::ST_INT;
            edge_cnt_reg <= 2'h0;
            engaged_reg  <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            edge_cnt_reg <= edge_cnt_next;
            engaged_reg  <= engaged_next;
        end
    end

    // ============================================================
    // clocks, oscillator enables and pins
    logic run_ok;
    logic bus4_reg;
    logic bus4_next;
    logic bus2_reg;
    logic bus2_next;
    logic int_en_reg;
    logic int_en_next;
    logic xtal_en_reg;
    logic xtal_en_next;
    logic rc_en_reg;
    logic rc_en_next;
    logic pin1_en_reg;
    logic pin1_en_next;
    logic pin2_oe_reg;
    logic pin2_oe_next;
    logic pin2_out_reg;
    logic pin2_out_next;
    logic xtal_mode_reg;
    logic xtal_mode_next;

    always_comb
    begin
        run_ok = integration_osc_enable_i | osc_run_in_stop_cfg_i;
        bus4_next = sel_lvl;
        // times-two toggles on each times-four rise, bus clock is a further halving
        bus2_next = (bus4_next && !bus4_reg) ? !bus2_reg : bus2_reg;
        // internal stops only the cycle after engaged is shown
        int_en_next  = run_ok && !(state_reg == ocs_pkg::ST_EXT && engaged_reg);
        xtal_en_next = run_ok && ctrl_reg.source_option_field == ocs_pkg::OPT_CRYSTAL;
        rc_en_next   = run_ok && ctrl_reg.source_option_field == ocs_pkg::OPT_RC;
        pin1_en_next = ctrl_reg.source_option_field != ocs_pkg::OPT_INTERNAL;
        xtal_mode_next = ctrl_reg.source_option_field == ocs_pkg::OPT_CRYSTAL;
        pin2_oe_next = pin2_en_reg
                       && (ctrl_reg.source_option_field == ocs_pkg::OPT_INTERNAL
                           || ctrl_reg.source_option_field == ocs_pkg::OPT_RC);
        pin2_out_next = pin2_oe_next && bus4_next;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus4_reg      <= 1'b0;
            bus2_reg      <= 1'b0;
            int_en_reg    <= 1'b1;
            xtal_en_reg   <= 1'b0;
            rc_en_reg     <= 1'b0;
            pin1_en_reg   <= 1'b0;
            pin2_oe_reg   <= 1'b0;
            pin2_out_reg  <= 1'b0;
            xtal_mode_reg <= 1'b0;
        end
        else
        begin
            bus4_reg      <= bus4_next;
            bus2_reg      <= bus2_next;
            int_en_reg    <= int_en_next;
            xtal_en_reg   <= xtal_en_next;
            rc_en_reg     <= rc_en_next;
            pin1_en_reg   <= pin1_en_next;
            pin2_oe_reg   <= pin2_oe_next;
            pin2_out_reg  <= pin2_out_next;
            xtal_mode_reg <= xtal_mode_next;
        end
    end

    assign reg_rdata_o              = rdata_reg;
    assign internal_osc_enable_o    = int_en_reg;
    assign crystal_osc_enable_o     = xtal_en_reg;
    assign rc_osc_enable_o          = rc_en_reg;
    assign internal_freq_field_o    = ctrl_reg.internal_freq_field;
    assign internal_trim_value_o    = trim_reg;
    assign crystal_range_field_o    = ctrl_reg.crystal_range_field;
    assign pin1_clock_input_en_o    = pin1_en_reg;
    assign pin2_crystal_mode_o      = xtal_mode_reg;
    assign osc_pin_two_o            = pin2_out_reg;
    assign osc_pin_two_oe_o         = pin2_oe_reg;
    assign bus_clock_times_four_o   = bus4_reg;
    assign bus_clock_times_two_o    = bus2_reg;
    assign external_clock_engaged_o = engaged_reg;

    // ============================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    engaged_first_a: assert property ($rose(engaged_reg) |-> int_en_reg ##1 !int_en_reg)
        else $error("internal oscillator stopped before engaged was shown");
    two_edges_a: assert property ((state_reg == ocs_pkg::ST_CHECK
        && state_next == ocs_pkg::ST_GATE_EXT) |-> edge_cnt_reg == 2'h2)
        else $error("switch began before two external edges");
    gate_low_a: assert property ((state_reg == ocs_pkg::ST_GATE_EXT) |=> !bus4_reg)
        else $error("times-four not held low during handover");
    freq_legal_a: assert property (ctrl_reg.internal_freq_field != ocs_pkg::FREQ_RESERVED)
        else $error("reserved internal frequency accepted");
    pin2_forced_a: assert property (ctrl_reg.source_option_field == ocs_pkg::OPT_EXT_CLOCK
        |-> !pin2_en_reg)
        else $error("pin two enable not forced clear");
    xtal_pin_a: assert property ((ctrl_reg.source_option_field == ocs_pkg::OPT_CRYSTAL
        && $past(ctrl_reg.source_option_field) == ocs_pkg::OPT_CRYSTAL) |-> !osc_pin_two_oe_o)
        else $error("pin two driven in crystal mode");
    stop_gate_a: assert property ((!integration_osc_enable_i && !osc_run_in_stop_cfg_i)
        |=> !int_en_reg && !xtal_en_reg && !rc_en_reg)
        else $error("oscillator left running in stop");
    half_rate_a: assert property ($changed(bus2_reg) |-> $rose(bus4_reg))
        else $error("times-two changed without a times-four rise");
    pin1_input_a: assert property ((ctrl_reg.source_option_field != ocs_pkg::OPT_INTERNAL)
        |=> pin1_en_reg)
        else $error("pin one not enabled as clock input");
    trim_write_a: assert property ($changed(trim_reg)
        |-> $past(reg_write_i) && $past(reg_addr_i) == `OCS_ADDR_TRIM)
        else $error("trim changed without a software write");

endmodule : ocs_clock_switch

`default_nettype wire

// file: rtl/ocs_defines.svh
// register offsets, field positions, reset values and counts of the clock switch
`ifndef OCS_DEFINES_SVH
`define OCS_DEFINES_SVH

// ============================================================
// register offsets
`define OCS_ADDR_CTRL      8'h00
`define OCS_ADDR_TRIM      8'h01
`define OCS_ADDR_PIN2      8'h02

// ============================================================
// field positions in the control register
`define OCS_OPT_LSB        6
`define OCS_FREQ_LSB       4
`define OCS_RANGE_LSB      2
`define OCS_EXT_ON_BIT     1
`define OCS_ENGAGED_BIT    0
// field position in the pin two register
`define OCS_PIN2_EN_BIT    0

// ============================================================
// reset values
`define OCS_OPT_RST        2'h0
`define OCS_FREQ_RST       2'h2
`define OCS_RANGE_RST      2'h0
`define OCS_TRIM_RST       8'h80

// ============================================================
// timing counts
`define OCS_EDGES_NEEDED   2'h2

`endif

// file: rtl/ocs_pkg.sv
// types of the oscillator clock switch
package ocs_pkg;

    // ============================================================
    // source option field
    typedef enum logic [1:0] {
        OPT_INTERNAL  = 2'h0,
        OPT_EXT_CLOCK = 2'h1,
        OPT_RC        = 2'h2,
        OPT_CRYSTAL   = 2'h3
    } ocs_opt_e;

    // internal frequency field
    typedef enum logic [1:0] {
        FREQ_4M0      = 2'h0,
        FREQ_8M0      = 2'h1,
        FREQ_12M8     = 2'h2,
        FREQ_RESERVED = 2'h3
    } ocs_freq_e;

    // ============================================================
    // handover states, gray along int-check-gate-ext-return
    typedef enum logic [2:0] {
        ST_INT      = 3'h0,
        ST_CHECK    = 3'h1,
        ST_GATE_EXT = 3'h3,
        ST_EXT      = 3'h2,
        ST_RETURN   = 3'h6
    } ocs_state_e;

    // ============================================================
    // software control fields
    typedef struct packed {
        ocs_opt_e   source_option_field;
        ocs_freq_e  internal_freq_field;
        logic [1:0] crystal_range_field;
        logic       external_clock_on;
    } ocs_ctrl_s;

endpackage : ocs_pkg

// file: test/ocs_clock_switch_tb_top.sv
// self-checking bench of the oscillator clock switch
`timescale 1ns/1ps
`include "ocs_defines.svh"
`default_nettype none

module ocs_clock_switch_tb_top;
    // ============================================================
    // signals and model state
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       sim_en = 1'b1;
    logic       stop_cfg = 1'b0;
    logic [7:0] rdata, trim_o;
    logic [1:0] freq_o, range_o;
    logic       int_clk, xtal_clk, rc_clk, pin1_clk, int_en, xtal_en, rc_en;
    logic       pin1_en, xmode, p2, p2_oe, x4, x2, eng;
    int         checks = 0;
    int         n_mismatch = 0;
    int         cyc = 0;
    int         n;
    int         m_opt, m_freq, m_rng, m_ext, m_eng, m_trim, m_p2;
    int         opt_seq[4] = '{0, 2, 3, 1};
    real        per_tab[3] = '{128.0, 64.0, 40.0};

    ocs_clock_switch dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
        .integration_osc_enable_i(sim_en), .osc_run_in_stop_cfg_i(stop_cfg),
        .internal_osc_clock_i(int_clk), .crystal_clock_i(xtal_clk),
        .resistor_cap_clock_i(rc_clk), .osc_pin_one_i(pin1_clk),
        .internal_osc_enable_o(int_en), .crystal_osc_enable_o(xtal_en),
        .rc_osc_enable_o(rc_en), .internal_freq_field_o(freq_o),
        .internal_trim_value_o(trim_o), .crystal_range_field_o(range_o),
        .pin1_clock_input_en_o(pin1_en), .pin2_crystal_mode_o(xmode),
        .osc_pin_two_o(p2), .osc_pin_two_oe_o(p2_oe), .bus_clock_times_four_o(x4),
        .bus_clock_times_two_o(x2), .external_clock_engaged_o(eng)
    );

    ocs_source_model src (
        .int_en_i(int_en), .xtal_en_i(xtal_en), .rc_en_i(rc_en), .freq_i(freq_o),
        .trim_i(trim_o), .int_clk_o(int_clk), .xtal_clk_o(xtal_clk),
        .rc_clk_o(rc_clk), .pin1_clk_o(pin1_clk)
    );

    always #2.5 clk_i = ~clk_i;

    // hang guard, well above the length of the sequence
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // ============================================================
    // tasks
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    // write also updates the integer model of the registers
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        if (a == `OCS_ADDR_CTRL)
        begin
            m_opt = d[7:6];
            m_freq = (d[5:4] == 2'h3) ? m_freq : int'(d[5:4]);
            m_rng = d[3:2];
            m_ext = d[1];
            m_p2 = (m_opt == 1) ? 0 : m_p2;
        end
        else if (a == `OCS_ADDR_TRIM)
            m_trim = d;
        else if (a == `OCS_ADDR_PIN2 && m_opt != 1)
            m_p2 = d[0];
    endtask : wr_reg

    function automatic logic [7:0] expv(input logic [7:0] a);
        case (a)
            `OCS_ADDR_CTRL: return 8'((m_opt << 6) | (m_freq << 4) | (m_rng << 2)
                                      | (m_ext << 1) | m_eng);
            `OCS_ADDR_TRIM: return 8'(m_trim);
            `OCS_ADDR_PIN2: return 8'(m_p2);
            default: return 8'h00;
        endcase
    endfunction : expv

    task automatic chk_reg(input logic [7:0] a);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        cmp(rdata, expv(a));
    endtask : chk_reg

    task automatic chk_out();
        repeat (3) @(posedge clk_i);
        #1;
        cmp(8'(freq_o), 8'(m_freq));
        cmp(trim_o, 8'(m_trim));
        cmp(8'(range_o), 8'(m_rng));
        cmp(8'(pin1_en), 8'(m_opt != 0));
        cmp(8'(xmode), 8'(m_opt == 3));
        cmp(8'(p2_oe), 8'(m_p2 && (m_opt == 0 || m_opt == 2)));
    endtask : chk_out

    // counts clock rises over 4 us against the source period
    task automatic meas(input real per);
        int c4;
        int c2;
        int e;
        logic q4;
        logic q2;
        c4 = 0;
        c2 = 0;
        e = int'(4000.0 / per);
        q4 = x4;
        q2 = x2;
        repeat (800)
        begin
            @(posedge clk_i);
            #1;
            c4 += int'(x4 && !q4);
            c2 += int'(x2 && !q2);
            q4 = x4;
            q2 = x2;
        end
        cmp(8'(c4 >= e - 2 && c4 <= e + 2), 8'h01);
        cmp(8'(c2 >= e / 2 - 2 && c2 <= e / 2 + 2), 8'h01);
    endtask : meas

    // ============================================================
    // sequence
    initial
    begin
        void'($urandom(14556));
        m_opt = 0;
        m_freq = 2;
        m_rng = 0;
        m_ext = 0;
        m_eng = 0;
        m_trim = 8'h80;
        m_p2 = 0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        cmp(8'(int_en), 8'h01);
        for (int a = 0; a < 4; a++)
            chk_reg(8'(a));
        // reserved frequency first, it must leave the setting alone
        for (int f = 3; f >= 0; f--)
        begin
            wr_reg(`OCS_ADDR_CTRL, 8'(f << 4));
            chk_out();
            meas(per_tab[m_freq]);
        end
        repeat (4)
        begin
            wr_reg(`OCS_ADDR_TRIM, 8'($urandom));
            chk_reg(`OCS_ADDR_TRIM);
            chk_out();
        end
        wr_reg(`OCS_ADDR_TRIM, 8'h80);
        foreach (opt_seq[i])
        begin
            wr_reg(`OCS_ADDR_CTRL, 8'((opt_seq[i] << 6) | ($urandom_range(3) << 2)) | 8'h20);
            wr_reg(`OCS_ADDR_PIN2, 8'h01);
            chk_reg(`OCS_ADDR_PIN2);
            chk_out();
            repeat (8)
            begin
                @(posedge clk_i);
                #1;
                cmp(8'(p2), 8'(p2_oe & x4));
            end
            // oscillator enables under every stop combination
            for (int s = 0; s < 4; s++)
            begin
                @(posedge clk_i);
                sim_en <= s[0];
                stop_cfg <= s[1];
                repeat (3) @(posedge clk_i);
                #1;
                cmp(8'(int_en), 8'(s != 0));
                cmp(8'(xtal_en), 8'(s != 0 && opt_seq[i] == 3));
                cmp(8'(rc_en), 8'(s != 0 && opt_seq[i] == 2));
            end
        end
        // handover to the external clock on pin one
        wr_reg(`OCS_ADDR_CTRL, 8'h62);
        n = 0;
        while (eng !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        cmp(8'(eng), 8'h01);
        cmp(8'(n >= 15), 8'h01);
        cmp(8'(int_en), 8'h01);
        @(posedge clk_i);
        #1;
        cmp(8'(int_en), 8'h00);
        m_eng = 1;
        chk_reg(`OCS_ADDR_CTRL);
        meas(100.0);
        wr_reg(`OCS_ADDR_CTRL, 8'he2);
        chk_out();
        cmp(8'(xtal_en), 8'h01);
        meas(60.0);
        // back to the internal source
        wr_reg(`OCS_ADDR_CTRL, 8'h20);
        n = 0;
        while (eng !== 1'b0 && n < 400)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        m_eng = 0;
        cmp(8'(eng), 8'h00);
        cmp(8'(int_en), 8'h01);
        chk_reg(`OCS_ADDR_CTRL);
        meas(40.0);
        test_done();
    end
endmodule : ocs_clock_switch_tb_top

`default_nettype wire

// file: test/ocs_source_model.sv
// far-side model: raw oscillators and an external clock on pin one
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// source model
module ocs_source_model (
    // oscillator controls
    input  wire logic       int_en_i,
    input  wire logic       xtal_en_i,
    input  wire logic       rc_en_i,
    input  wire logic [1:0] freq_i,
    input  wire logic [7:0] trim_i,
    // source clocks
    output var  logic       int_clk_o,
    output var  logic       xtal_clk_o,
    output var  logic       rc_clk_o,
    output var  logic       pin1_clk_o
);
    real half;

    // periods of 128, 64 or 40 ns for the 4.0, 8.0 and 12.8 MHz codes; one trim step is 0.2 percent of the period
    // case keeps an unknown field before reset on a usable, nonzero period
    initial
    begin
        int_clk_o = 1'b0;
        forever
        begin
            case (freq_i)
                2'h0:    half = 64.0;
                2'h1:    half = 32.0;
                default: half = 20.0;
            endcase
            half = half * (1.0 + 0.002 * (real'(trim_i) - 128.0));
            #(half);
            // a disabled oscillator parks low
            int_clk_o = int_en_i ? ~int_clk_o : 1'b0;
        end
    end

    initial
    begin
        xtal_clk_o = 1'b0;
        forever
        begin
            #30.0;
            xtal_clk_o = xtal_en_i ? ~xtal_clk_o : 1'b0;
        end
    end

    initial
    begin
        rc_clk_o = 1'b0;
        forever
        begin
            #40.0;
            rc_clk_o = rc_en_i ? ~rc_clk_o : 1'b0;
        end
    end

    // external clock runs free, it is not ours to stop
    initial
    begin
        pin1_clk_o = 1'b0;
        forever
        begin
            #50.0;
            pin1_clk_o = ~pin1_clk_o;
        end
    end
endmodule : ocs_source_model

`default_nettype wire
